// ==== core/lscg_gate.v ====
// line-scan acquisition gate: scan control, buffer filling, triggers
`timescale 1ns/100ps
`include "lscg_consts.vh"

// Behaviour
// - immediate source: scan at next line boundary
// - software-stop finish: close on software finish event or end request
// - triggered: begin request only arms start trigger
// - start event from software or selected input
// - start events ignored while scanning
// - gate opens at boundary after start event
// - length finish: close after count or request
// - variable: close next boundary, request closes now
// - finish event from software or selected input
// - finish events ignored while not scanning
// - first line at start of fresh buffer
// - flip layout: first line in last slot
// - lines never straddle buffers; an end request mid-line releases the cut line, counted as one line
// - full buffer released, continue in new one
// - end of scan releases last buffer at once
// - divider passes one of every N events
// - ratio converter 0.001..1000, exact average rate
// - encoder events turned into camera triggers
// - single output channel, latency under a line
module lscg_gate #(
    parameter DW = 32,
    parameter LW = 16
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [7:0]    paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire          cam_line_start,
    input  wire          cam_valid,
    input  wire [DW-1:0] cam_data,
    input  wire          cam_line_end,
    input  wire          line_input_one,
    input  wire          line_input_two,
    input  wire          encoder_event,
    output reg           dma_valid,
    output reg  [DW-1:0] dma_data,
    output reg  [LW-1:0] dma_line_slot,
    output reg           dma_buf_release,
    output reg  [LW-1:0] dma_buf_lines,
    output reg           cam_trigger,
    output reg           scan_active
);

    // scan states: idle, armed, waiting for a boundary, gate open
    localparam ST_IDLE  = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_PEND  = 2'h2;
    localparam ST_SCAN  = 2'h3;

    ////////////////////////////////////////////////////////////////////
    // register file
    reg  [`LSCG_C_W-1:0] ctrl_r;
    reg  [LW-1:0]        scan_len_r;
    reg  [LW-1:0]        buf_lines_r;
    reg  [LW-1:0]        div_n_r;
    reg  [LW-1:0]        rmul_r;
    reg  [LW-1:0]        rdiv_r;
    reg  [`LSCG_K_W-1:0] cmd_r;
    reg  [1:0]           state_r;
    reg  [LW-1:0]        line_cnt_r;
    reg  [LW-1:0]        used_r;
    reg                  fin_pend_r;
    reg  [31:0]          rd_nxt;
    reg                  err_nxt;

    // bus phase decode and control fields
    wire                 acc_ph = psel & penable;
    wire                 wr_go  = acc_ph & pready & pwrite;
    wire [1:0]           bsel   = ctrl_r[`LSCG_C_BSEL];
    wire [1:0]           fsel   = ctrl_r[`LSCG_C_FSEL];
    wire                 flip   = ctrl_r[`LSCG_C_FLIP];

    // read mux and decode; unmapped offsets answer with an error
    always @* begin
        rd_nxt  = 32'h0;
        err_nxt = 1'b0;
        if (paddr == `LSCG_A_CTRL) begin
            rd_nxt[`LSCG_C_W-1:0] = ctrl_r;
        end else if (paddr == `LSCG_A_CMD) begin
            rd_nxt = 32'h0;
        end else if (paddr == `LSCG_A_SCANLEN) begin
            rd_nxt[LW-1:0] = scan_len_r;
        end else if (paddr == `LSCG_A_BUFLINES) begin
            rd_nxt[LW-1:0] = buf_lines_r;
        end else if (paddr == `LSCG_A_DIVN) begin
            rd_nxt[LW-1:0] = div_n_r;
        end else if (paddr == `LSCG_A_RMUL) begin
            rd_nxt[LW-1:0] = rmul_r;
        end else if (paddr == `LSCG_A_RDIV) begin
            rd_nxt[LW-1:0] = rdiv_r;
        end else if (paddr == `LSCG_A_STATUS) begin
            // state, flag, pending finish, lines used
            rd_nxt[`LSCG_S_STATE]      = state_r;
            rd_nxt[`LSCG_S_SCAN]       = scan_active;
            rd_nxt[`LSCG_S_FPEND]      = fin_pend_r;
            rd_nxt[`LSCG_S_USED +: LW] = used_r;
        end else if (paddr == `LSCG_A_LINECNT) begin
            rd_nxt[LW-1:0] = line_cnt_r;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_ph & ~pready;
            prdata  <= (acc_ph & ~pready & ~pwrite) ? rd_nxt : 32'h0;
            pslverr <= acc_ph & ~pready & err_nxt;
        end
    end

    // writes land at the edge where pready is seen high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r      <= `LSCG_R_CTRL;
            scan_len_r  <= `LSCG_R_SCANLEN;
            buf_lines_r <= `LSCG_R_BUFLINES;
            div_n_r     <= `LSCG_R_DIVN;
            rmul_r      <= `LSCG_R_RATIO;
            rdiv_r      <= `LSCG_R_RATIO;
        end else begin
            if (wr_go && !err_nxt) begin
                if (paddr == `LSCG_A_CTRL)
                    ctrl_r <= pwdata[`LSCG_C_W-1:0];
                else if (paddr == `LSCG_A_SCANLEN)
                    scan_len_r <= pwdata[LW-1:0];
                else if (paddr == `LSCG_A_BUFLINES)
                    buf_lines_r <= pwdata[LW-1:0];
                else if (paddr == `LSCG_A_DIVN)
                    div_n_r <= pwdata[LW-1:0];
                else if (paddr == `LSCG_A_RMUL)
                    rmul_r <= pwdata[LW-1:0];
                else if (paddr == `LSCG_A_RDIV)
                    rdiv_r <= pwdata[LW-1:0];
            end
        end
    end

    // command pulses live for one clock, then act on the next edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= {`LSCG_K_W{1'b0}};
        end else if (wr_go && paddr == `LSCG_A_CMD) begin
            cmd_r <= pwdata[`LSCG_K_W-1:0];
        end else begin
            cmd_r <= {`LSCG_K_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // scan control
    // command bits, each a one-clock pulse
    wire acq_beg = cmd_r[`LSCG_K_ACQ_BEG];
    wire acq_end = cmd_r[`LSCG_K_ACQ_END];
    wire sw_beg  = cmd_r[`LSCG_K_SW_BEG];
    wire sw_fin  = cmd_r[`LSCG_K_SW_FIN];

    // valid start and finish events
    wire beg_ev = sw_beg
                | (bsel == `LSCG_B_LINE_INPUT_ONE && line_input_one)
                | (bsel == `LSCG_B_LINE_INPUT_TWO && line_input_two);
    wire fin_ev = (fsel != `LSCG_F_LEN && sw_fin)
                | (fsel == `LSCG_F_LINE_INPUT_ONE && line_input_one)
                | (fsel == `LSCG_F_LINE_INPUT_TWO && line_input_two);

    // length reached once the counted line is the programmed last;
    // a length of zero behaves as one
    wire len_done = (fsel == `LSCG_F_LEN) &&
                    (line_cnt_r >= scan_len_r);
    // boundary close: pending finish event or length complete
    wire bnd_close = cam_line_start && (fin_pend_r || len_done);
    wire close_now = (state_r == ST_SCAN) && (acq_end || bnd_close);
    // after a boundary close a triggered scan re-arms
    wire rearm = (bsel != `LSCG_B_IMMED) && !acq_end;

    // scan state machine; the scan flag follows the gate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= ST_IDLE;
            scan_active <= 1'b0;
            fin_pend_r  <= 1'b0;
            line_cnt_r  <= {LW{1'b0}};
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (acq_beg) begin
                        if (bsel == `LSCG_B_IMMED)
                            state_r <= ST_PEND;
                        else
                            state_r <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (acq_end)
                        state_r <= ST_IDLE;
                    else if (beg_ev)
                        state_r <= ST_PEND;
                end
                ST_PEND: begin
                    if (acq_end) begin
                        state_r <= ST_IDLE;
                    end else if (cam_line_start) begin
                        state_r     <= ST_SCAN;
                        scan_active <= 1'b1;
                        line_cnt_r  <= {{(LW-1){1'b0}}, 1'b1};
                        fin_pend_r  <= 1'b0;
                    end
                end
                ST_SCAN: begin
                    // start events fall through unseen here
                    if (close_now) begin
                        state_r     <= rearm ? ST_ARMED : ST_IDLE;
                        scan_active <= 1'b0;
                        fin_pend_r  <= 1'b0;
                    end else begin
                        if (fin_ev)
                            fin_pend_r <= 1'b1;
                        if (cam_line_start)
                            line_cnt_r <= line_cnt_r + 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            // finish events outside a scan are dropped: the pending
            // flag is only ever set in the scan state
        end
    end

    ////////////////////////////////////////////////////////////////////
    // line data path and buffer filling
    // buffer slot bookkeeping
    reg           in_line_r;
    reg  [LW-1:0] slot_r;
    wire          gate_line  = (state_r == ST_SCAN) && !close_now;
    wire [LW-1:0] last_slot  = buf_lines_r - 1'b1;
    wire          buf_full   = (used_r + 1'b1) >= buf_lines_r;
    // flip layout fills a buffer from its last slot downwards
    wire [LW-1:0] first_slot = flip ? last_slot : {LW{1'b0}};
    // a line is taken only if its start lies inside the gate; its
    // first word comes with the start pulse and is taken at once
    wire          take_line  = cam_line_start &&
                               (gate_line || state_r == ST_PEND);
    wire          word_in    = cam_line_start ? take_line : in_line_r;
    // the opening line must not inherit the slot of the last scan
    wire [LW-1:0] cur_slot   = (state_r == ST_PEND) ? first_slot : slot_r;

    // line window: open from a taken start to the line's end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_line_r <= 1'b0;
        end else begin
            if (cam_line_start)
                in_line_r <= take_line;
            else if (cam_line_end || close_now)
                in_line_r <= 1'b0;
        end
    end

    // single channel, one register of latency
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_valid     <= 1'b0;
            dma_data      <= {DW{1'b0}};
            dma_line_slot <= {LW{1'b0}};
        end else begin
            dma_valid <= 1'b0;
            if (word_in && cam_valid) begin
                dma_valid     <= 1'b1;
                dma_data      <= cam_data;
                dma_line_slot <= cur_slot;
            end
        end
    end

    // buffer accounting; a line counts once its end is seen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_r          <= {LW{1'b0}};
            used_r          <= {LW{1'b0}};
            dma_buf_release <= 1'b0;
            dma_buf_lines   <= {LW{1'b0}};
        end else begin
            dma_buf_release <= 1'b0;
            if (state_r == ST_PEND && cam_line_start) begin
                // fresh buffer for the first line
                slot_r <= first_slot;
                used_r <= {LW{1'b0}};
            end
            if (close_now) begin
                // partial buffer goes out at once
                dma_buf_release <= 1'b1;
                dma_buf_lines   <= used_r + (in_line_r ? 1'b1 : 1'b0);
                used_r          <= {LW{1'b0}};
            end else if (in_line_r && cam_line_end) begin
                // lines never straddle two buffers
                if (buf_full) begin
                    dma_buf_release <= 1'b1;
                    dma_buf_lines   <= buf_lines_r;
                    used_r          <= {LW{1'b0}};
                    slot_r          <= first_slot;
                end else begin
                    used_r <= used_r + 1'b1;
                    slot_r <= flip ? slot_r - 1'b1 : slot_r + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // encoder to camera trigger conversion
    reg [LW-1:0]   div_cnt_r;
    reg [2*LW:0]   racc_r;
    wire           div_hit = (div_cnt_r + 1'b1) >= div_n_r;
    wire [2*LW:0]  racc_add = racc_r +
                   (encoder_event ? {{(LW+1){1'b0}}, rmul_r}
                                  : {(2*LW+1){1'b0}});
    wire           r_emit = racc_add >= {{(LW+1){1'b0}}, rdiv_r} &&
                            rdiv_r != {LW{1'b0}};

    // divider: one of N incoming events, N of zero acts as one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= {LW{1'b0}};
        end else if (encoder_event) begin
            if (div_hit)
                div_cnt_r <= {LW{1'b0}};
            else
                div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    // ratio: the remainder stays in the accumulator, so the average
    // rate is exact; one trigger per clock, bursts are spread later
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            racc_r <= {(2*LW+1){1'b0}};
        end else begin
            if (r_emit)
                racc_r <= racc_add - {{(LW+1){1'b0}}, rdiv_r};
            else
                racc_r <= racc_add;
        end
    end

    // trigger output, chosen by the cycle method bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cam_trigger <= 1'b0;
        end else begin
            if (ctrl_r[`LSCG_C_METH])
                cam_trigger <= r_emit;
            else
                cam_trigger <= encoder_event && div_hit;
        end
    end

endmodule // lscg_gate

// ==== core/lscg_consts.vh ====
// constants of the line-scan acquisition gate
`ifndef LSCG_CONSTS_VH
`define LSCG_CONSTS_VH
// register byte offsets
`define LSCG_A_CTRL     8'h00
`define LSCG_A_CMD      8'h04
`define LSCG_A_SCANLEN  8'h08
`define LSCG_A_BUFLINES 8'h0c
`define LSCG_A_DIVN     8'h10
`define LSCG_A_RMUL     8'h14
`define LSCG_A_RDIV     8'h18
`define LSCG_A_STATUS   8'h1c
`define LSCG_A_LINECNT  8'h20
// control fields
`define LSCG_C_BSEL     1:0
`define LSCG_C_FSEL     3:2
`define LSCG_C_FLIP     4
`define LSCG_C_METH     5
`define LSCG_C_W        6
// command bits
`define LSCG_K_ACQ_BEG  0
`define LSCG_K_ACQ_END  1
`define LSCG_K_SW_BEG   2
`define LSCG_K_SW_FIN   3
`define LSCG_K_W        4
// status fields
`define LSCG_S_STATE    1:0
`define LSCG_S_SCAN     2
`define LSCG_S_FPEND    3
`define LSCG_S_USED     16
// begin source codes
`define LSCG_B_IMMED    2'h0
`define LSCG_B_SW       2'h1
`define LSCG_B_LINE_INPUT_ONE     2'h2
`define LSCG_B_LINE_INPUT_TWO     2'h3
// finish source codes
`define LSCG_F_SW       2'h0
`define LSCG_F_LEN      2'h1
`define LSCG_F_LINE_INPUT_ONE     2'h2
`define LSCG_F_LINE_INPUT_TWO     2'h3
// reset values
`define LSCG_R_CTRL     6'h00
`define LSCG_R_SCANLEN  16'h0001
`define LSCG_R_BUFLINES 16'h0010
`define LSCG_R_DIVN     16'h0001
`define LSCG_R_RATIO    16'h0001
`endif

// ==== tb/lscg_asserts.sv ====
// concurrent checks on the acquisition gate ports
`timescale 1ns/100ps
module lscg_asserts (
    input logic        pclk, presetn, psel, penable, pready, pslverr,
    input logic        cam_line_start, cam_valid, scan_active,
    input logic        dma_valid, dma_buf_release,
    input logic [7:0]  paddr,
    input logic [31:0] prdata, cam_data, dma_data
);
    // one clock domain, reset masks every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // camera words reach the dma side exactly one cycle later
    dma_lat_a:
        assert property (dma_valid |-> $past(cam_valid))
        else $error("dma word without camera word");
    dma_word_a:
        assert property (dma_valid |-> dma_data == $past(cam_data))
        else $error("dma word differs from camera word");
    // the gate only opens on a camera line boundary
    gate_open_a:
        assert property ($rose(scan_active) |-> $past(cam_line_start))
        else $error("gate opened off a line boundary");
    gated_data_a:
        assert property (dma_valid |-> scan_active || $past(scan_active))
        else $error("data passed with the gate closed");
    // release comes in the cycle the flag falls; a cycle before or up to three after is allowed
    end_release_a:
        assert property ($fell(scan_active) |->
            $past(dma_buf_release) or ##[0:3] dma_buf_release)
        else $error("no buffer release at end of scan");
    // bus side: exactly one wait state, one-cycle answer
    apb_wait_a:
        assert property (psel && penable && !$past(penable) |->
            !pready ##1 pready)
        else $error("bus answer not after one wait state");
    ready_pulse_a:
        assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    rdata_idle_a:
        assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    map_err_a:
        assert property (pready |->
            pslverr == (paddr > 8'h20 || paddr[1:0] != 2'h0))
        else $error("error flag wrong for the address");
    cover property ($rose(scan_active));
    cover property (dma_buf_release);
    cover property (pready && pslverr);
endmodule // lscg_asserts

bind lscg_gate lscg_asserts lscg_asserts_i (.*);

// ==== tb/lscg_cam_model.sv ====
// camera line stream model driving the gate's link side
`timescale 1ns/100ps
module lscg_cam_model #(parameter WPL = 4, parameter GAP = 2) (
    input  wire        pclk, presetn, go, slow,
    input  wire [7:0]  n,
    output wire        busy, cam_line_start, cam_valid, cam_line_end,
    output reg  [31:0] cam_data
);
    localparam [7:0] SPAN_F = WPL;
    localparam [7:0] SPAN_S = 2 * WPL - 1;
    localparam [7:0] G      = GAP;
    reg  [7:0] left_r;
    reg  [7:0] t_r;
    wire [7:0] span = slow ? SPAN_S : SPAN_F;
    wire       last = t_r == span + G - 8'h01;
    ////////////////////////////////////////////////////////////
    // slow mode leaves a hole after each word; gap keeps lines apart
    assign busy           = left_r != 8'h00;
    assign cam_line_start = busy && t_r == 8'h00;
    assign cam_valid      = busy && t_r < span && !(slow && t_r[0]);
    assign cam_line_end   = busy && t_r == span - 8'h01;
    // data moves every cycle, so a word outside valid is never stale
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r   <= 8'h00;
            t_r      <= 8'h00;
            cam_data <= 32'h0;
        end else begin
            cam_data <= cam_data + 32'h01010101;
            t_r      <= (go || last) ? 8'h00 : t_r + 8'h01;
            if (go)
                left_r <= n;
            else if (busy && last)
                left_r <= left_r - 8'h01;
        end
    end
endmodule // lscg_cam_model

// ==== tb/line_scan_acquisition_gate_tb.sv ====
// self-checking bench for the line-scan acquisition gate
`timescale 1ns/100ps
`include "lscg_consts.vh"
module line_scan_acquisition_gate_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cam_line_start, cam_valid, cam_line_end, go, slow, busy;
    logic        line_input_one, line_input_two, encoder_event, e;
    logic        dma_valid, dma_buf_release, cam_trigger, scan_active;
    logic [7:0]  paddr, n;
    logic [15:0] dma_line_slot, dma_buf_lines;
    logic [31:0] pwdata, prdata, cam_data, dma_data, q, rel_lines, slot0;
    int          bad_count, n_tests, rel_n, n_words, n_trig;
    logic [7:0]  ra [6] = '{`LSCG_A_CTRL, `LSCG_A_SCANLEN, `LSCG_A_BUFLINES,
                            `LSCG_A_DIVN, `LSCG_A_RMUL, `LSCG_A_RDIV};
    logic [15:0] rv [6] = '{16'h0, `LSCG_R_SCANLEN, `LSCG_R_BUFLINES,
                            `LSCG_R_DIVN, `LSCG_R_RATIO, `LSCG_R_RATIO};

    lscg_gate lscg_gate_i (.*);
    lscg_cam_model lscg_cam_model_i (.*);
    ////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // tally of what leaves the gate
    always @(posedge pclk) begin
        if (dma_buf_release === 1'b1) begin
            rel_n++;
            rel_lines = {16'h0, dma_buf_lines};
        end
        if (dma_valid === 1'b1) begin
            if (n_words == 0) slot0 = {16'h0, dma_line_slot};
            n_words++;
        end
        if (cam_trigger === 1'b1) n_trig++;
    end
    task clr;
        {rel_n, n_words, n_trig} = 96'h0;
        {rel_lines, slot0} = 64'h0;
    endtask
    task chk(input [31:0] s, input [31:0] x);
        n_tests++;
        if (s !== x) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task hang;
        bad_count++;
        final_report;
    endtask
    // request held until ready is seen high at an edge
    task apb(input [7:0] a, input w, input [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        repeat (20) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) hang;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task cam(input [7:0] k, input s);
        n <= k;
        slow <= s;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (400) begin
            @(posedge pclk);
            if (busy === 1'b0) break;
        end
        if (busy !== 1'b0) hang;
        repeat (4) @(posedge pclk);
    endtask
    // bit 2 encoder, bit 1 second input, bit 0 first input
    task pulse(input [2:0] m);
        {encoder_event, line_input_two, line_input_one} <= m;
        @(posedge pclk);
        {encoder_event, line_input_two, line_input_one} <= 3'h0;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////
    task t_regs;
        for (int i = 0; i < 6; i++) begin
            apb(ra[i], 1'b0, 32'h0);
            chk(q, {16'h0, rv[i]});
        end
        wr(`LSCG_A_SCANLEN, 32'hffff_abcd);
        apb(`LSCG_A_SCANLEN, 1'b0, 32'h0);
        chk(q, 32'h0000_abcd);
        apb(8'h24, 1'b0, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("regs done");
    endtask
    // immediate start, software stop, three-line buffers
    task t_cont;
        clr;
        wr(`LSCG_A_CTRL, 32'h0);
        wr(`LSCG_A_BUFLINES, 32'h3);
        wr(`LSCG_A_CMD, 32'h1);
        cam(8'd7, 1'b0);
        chk({31'h0, scan_active}, 32'h1);
        chk(rel_n, 2);
        chk(rel_lines, 32'h3);
        chk(slot0, 32'h0);
        chk(n_words, 28);
        wr(`LSCG_A_CMD, 32'h2);
        repeat (4) @(posedge pclk);
        chk({31'h0, scan_active}, 32'h0);
        chk(rel_n, 3);
        chk(rel_lines, 32'h1);
        $display("continuous done");
    endtask
    // software start, two-line length, flipped layout, slow camera
    task t_fixed;
        clr;
        wr(`LSCG_A_CTRL, 32'h15);
        wr(`LSCG_A_SCANLEN, 32'h2);
        wr(`LSCG_A_BUFLINES, 32'h4);
        wr(`LSCG_A_CMD, 32'h1);
        cam(8'd2, 1'b1);
        chk(n_words, 0);
        wr(`LSCG_A_CMD, 32'h4);
        cam(8'd4, 1'b1);
        chk(n_words, 8);
        chk(slot0, 32'h3);
        chk(rel_n, 1);
        chk(rel_lines, 32'h2);
        chk({31'h0, scan_active}, 32'h0);
        $display("fixed done");
    endtask
    // first input starts, second input finishes; stray events first
    task t_var;
        wr(`LSCG_A_CMD, 32'h2);
        wr(`LSCG_A_CTRL, 32'h0e);
        wr(`LSCG_A_BUFLINES, 32'h10);
        clr;
        pulse(3'b010);
        wr(`LSCG_A_CMD, 32'h1);
        pulse(3'b010);
        pulse(3'b001);
        cam(8'd1, 1'b0);
        pulse(3'b001);
        pulse(3'b010);
        cam(8'd3, 1'b0);
        chk(n_words, 4);
        chk(rel_n, 1);
        chk(rel_lines, 32'h1);
        $display("variable done");
    endtask
    // divide by three, then multiply by two
    task t_trig;
        clr;
        wr(`LSCG_A_CTRL, 32'h0);
        wr(`LSCG_A_DIVN, 32'h3);
        repeat (9) pulse(3'b100);
        repeat (6) @(posedge pclk);
        chk(n_trig, 3);
        clr;
        wr(`LSCG_A_CTRL, 32'h20);
        wr(`LSCG_A_RMUL, 32'h2);
        repeat (5) pulse(3'b100);
        repeat (8) @(posedge pclk);
        chk(n_trig, 10);
        $display("triggers done");
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, go, slow} = 5'h0;
        {line_input_one, line_input_two, encoder_event} = 3'h0;
        {paddr, n, pwdata} = 48'h0;
        {bad_count, n_tests} = 64'h0;
        clr;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_cont;
        t_fixed;
        t_var;
        t_trig;
        final_report;
    end
endmodule // line_scan_acquisition_gate_tb
